// ==== design/bspc_hiccup.sv ====
`default_nettype none
`include "bspc_defines.svh"
module bspc_hiccup #(
	parameter int WAIT_CYC = `BSPC_HICCUP_WAIT_CYC,
	parameter int HICCUP_CYC = `BSPC_HICCUP_TIME_CYC
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// Cycle events
	input  wire logic active,
	input  wire logic cycle_start,
	input  wire logic comp_clamped,
	// Fault state
	output logic      hiccup
);
	localparam int CW = $clog2(HICCUP_CYC + 1);
	logic [CW-1:0] count;

	// Elaboration check: the shared counter cannot serve a wait longer than the hiccup time
	if (WAIT_CYC < 1 || HICCUP_CYC < 1 || WAIT_CYC > HICCUP_CYC)
		$error("bspc_hiccup: bad counts");

	// Clamp counter doubles as hiccup timer
	always_ff @(posedge clock)
	begin
		if (!rstn || !active)
		begin
			count <= '0;
			hiccup <= 1'b0;
		end
		else if (cycle_start)
		begin
			if (hiccup)
			begin
				if (count == CW'(HICCUP_CYC - 1))
				begin
					hiccup <= 1'b0;
					count <= '0;
				end
				else
					count <= count + 1'b1;
			end
			else if (comp_clamped)
			begin
				if (count == CW'(WAIT_CYC))
				begin
					hiccup <= 1'b1;
					count <= '0;
				end
				else
					count <= count + 1'b1;
			end
			else
				count <= '0;
		end
	end
endmodule
`default_nettype wire

// ==== design/bspc_switch_ctrl.sv ====
`default_nettype none
`include "bspc_defines.svh"
module bspc_switch_ctrl #(
	parameter int DEADTIME_CYC = `BSPC_DEADTIME_CYC,
	parameter int MIN_OFF_CYC = `BSPC_MIN_OFF_CYC,
	parameter int HICCUP_WAIT = `BSPC_HICCUP_WAIT_CYC,
	parameter int HICCUP_TIME = `BSPC_HICCUP_TIME_CYC
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// Oscillator
	input  wire logic cycle_start,
	input  wire logic off_request,
	// Comparators
	input  wire logic input_supply_ok,
	input  wire logic enable_ok,
	input  wire logic boot_uv,
	input  wire logic feedback_over,
	input  wire logic feedback_release,
	input  wire logic peak_current_trip,
	input  wire logic comp_clamped,
	input  wire logic ls_source_over,
	input  wire logic ls_sink_over,
	// Gate commands
	output logic      hs_on,
	output logic      ls_on,
	// Status
	output logic      active,
	output logic      hiccup_out
);
	localparam int DW = $clog2(DEADTIME_CYC + 1);
	localparam int OW = $clog2(MIN_OFF_CYC + 1);

	// Elaboration check on the timing counts
	if (DEADTIME_CYC < 1 || MIN_OFF_CYC < 1)
		$error("bspc_switch_ctrl: bad timing");

	bspc_pkg::bspc_phase_e phase;
	bspc_pkg::bspc_phase_e dead_target;
	logic [DW-1:0] dead_cnt;
	logic [OW-1:0] off_cnt;
	logic          ovp;
	logic          sink_lock;
	logic          hs_pulsed;
	logic          hiccup;
	logic          run;
	logic          want_high;

	assign run = active && !hiccup;

	// Enable needs both the supply and the enable comparator
	always_ff @(posedge clock)
	begin
		if (!rstn)
			active <= 1'b0;
		else
			active <= input_supply_ok && enable_ok;
	end

	bspc_hiccup #(
		.WAIT_CYC   (HICCUP_WAIT),
		.HICCUP_CYC (HICCUP_TIME)
	) u_hiccup (
		.clock        (clock),
		.rstn         (rstn),
		.active       (active),
		.cycle_start  (cycle_start),
		.comp_clamped (comp_clamped),
		.hiccup       (hiccup)
	);

	always_ff @(posedge clock)
	begin
		if (!rstn)
			hiccup_out <= 1'b0;
		else
			hiccup_out <= hiccup;
	end

	// Overvoltage latch with hysteresis; release takes effect at a cycle start
	always_ff @(posedge clock)
	begin
		if (!rstn || !active)
			ovp <= 1'b0;
		else if (feedback_over)
			ovp <= 1'b1;
		else if (cycle_start && feedback_release)
			ovp <= 1'b0;
	end

	// Sinking lockout; set wins over clear
	always_ff @(posedge clock)
	begin
		if (!rstn || !active)
			sink_lock <= 1'b0;
		else if (ls_on && ls_sink_over)
			sink_lock <= 1'b1;
		else if (boot_uv || (hs_pulsed && phase != bspc_pkg::BSPC_HIGH))
			sink_lock <= 1'b0;
	end

	// Tracks that the high side ran since the sinking trip
	always_ff @(posedge clock)
	begin
		if (!rstn || !active || !sink_lock)
			hs_pulsed <= 1'b0;
		else if (phase == bspc_pkg::BSPC_HIGH)
			hs_pulsed <= 1'b1;
	end

	// High side is wanted at a cycle start unless a protection blocks it
	// A release seen at this cycle start already lets the high side in, not one cycle later
	assign want_high = run && !boot_uv && !(ovp && !feedback_release) && !feedback_over
		&& !ls_source_over;

	// Off-time counter: a very short off request is ignored to reach full duty
	always_ff @(posedge clock)
	begin
		if (!rstn || phase != bspc_pkg::BSPC_HIGH)
			off_cnt <= '0;
		else if (off_request && off_cnt != OW'(MIN_OFF_CYC))
			off_cnt <= off_cnt + 1'b1;
		else if (!off_request)
			off_cnt <= '0;
	end

	// Switch phase sequencing, every handover passes through dead time
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			phase <= bspc_pkg::BSPC_OFF;
			dead_target <= bspc_pkg::BSPC_OFF;
			dead_cnt <= '0;
		end
		else if (!run)
		begin
			phase <= bspc_pkg::BSPC_OFF;
			dead_cnt <= '0;
		end
		else
		begin
			case (phase)
				bspc_pkg::BSPC_OFF, bspc_pkg::BSPC_IDLE:
				begin
					if (boot_uv)
					begin
						phase <= bspc_pkg::BSPC_DEAD;
						dead_target <= bspc_pkg::BSPC_LOW;
						dead_cnt <= '0;
					end
					else if (cycle_start && want_high)
					begin
						phase <= bspc_pkg::BSPC_DEAD;
						dead_target <= bspc_pkg::BSPC_HIGH;
						dead_cnt <= '0;
					end
					else if (cycle_start && !sink_lock && phase == bspc_pkg::BSPC_IDLE)
					begin
						phase <= bspc_pkg::BSPC_DEAD;
						dead_target <= bspc_pkg::BSPC_LOW;
						dead_cnt <= '0;
					end
				end
				bspc_pkg::BSPC_DEAD:
				begin
					if (dead_target == bspc_pkg::BSPC_HIGH && (boot_uv || feedback_over))
						dead_target <= bspc_pkg::BSPC_LOW;
					else if (dead_cnt == DW'(DEADTIME_CYC - 1))
						phase <= dead_target;
					else
						dead_cnt <= dead_cnt + 1'b1;
				end
				bspc_pkg::BSPC_HIGH:
				begin
					// A held off request past the minimum off-time ends the pulse
					if (boot_uv || feedback_over || peak_current_trip
						|| (off_request && off_cnt == OW'(MIN_OFF_CYC)))
					begin
						phase <= bspc_pkg::BSPC_DEAD;
						dead_target <= bspc_pkg::BSPC_LOW;
						dead_cnt <= '0;
					end
				end
				bspc_pkg::BSPC_LOW:
				begin
					if (ls_sink_over && !boot_uv)
						phase <= bspc_pkg::BSPC_IDLE;
					else if (cycle_start && want_high)
					begin
						phase <= bspc_pkg::BSPC_DEAD;
						dead_target <= bspc_pkg::BSPC_HIGH;
						dead_cnt <= '0;
					end
				end
				default:
					phase <= bspc_pkg::BSPC_OFF;
			endcase
		end
	end

	// Gate outputs registered from the current phase and protection inputs
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			hs_on <= 1'b0;
			ls_on <= 1'b0;
		end
		else
		begin
			hs_on <= run && phase == bspc_pkg::BSPC_HIGH && !boot_uv && !feedback_over
				&& !peak_current_trip;
			ls_on <= run && phase == bspc_pkg::BSPC_LOW && !(ls_sink_over && !boot_uv)
				&& !hs_on;
		end
	end
endmodule
`default_nettype wire

// ==== include/bspc_defines.svh ====
`ifndef BSPC_DEFINES_SVH
`define BSPC_DEFINES_SVH
// Clock period in ns and timing figures
`define BSPC_CLK_PERIOD_NS     20
`define BSPC_MIN_OFF_NS        200
`define BSPC_MIN_OFF_CYC       ((`BSPC_MIN_OFF_NS + `BSPC_CLK_PERIOD_NS - 1) / `BSPC_CLK_PERIOD_NS)
`define BSPC_DEADTIME_CYC      2
// Hiccup figures in switching cycles
`define BSPC_HICCUP_WAIT_CYC   512
`define BSPC_HICCUP_TIME_CYC   16384
`endif

// ==== include/bspc_pkg.sv ====
`default_nettype none
package bspc_pkg;
	typedef enum logic [2:0]
	{
		BSPC_OFF   = 3'b000,
		BSPC_DEAD  = 3'b001,
		BSPC_HIGH  = 3'b011,
		BSPC_LOW   = 3'b010,
		BSPC_IDLE  = 3'b110
	} bspc_phase_e;
endpackage
`default_nettype wire

// ==== tb/bspc_osc_model.sv ====
`default_nettype none
// Free-running oscillator standing in for the converter clock
module bspc_osc_model #(
	parameter int PERIOD = 20
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// Cycle pulse
	output logic      cycle_start
);
	timeunit 1ns;
	timeprecision 1ns;
	int count;
	always_ff @(posedge clock)
	begin
		count       <= (!rstn || count == PERIOD - 1) ? 0 : count + 1;
		cycle_start <= rstn && count == PERIOD - 1;
	end
endmodule
`default_nettype wire

// ==== tb/bspc_switch_ctrl_asserts.sv ====
`default_nettype none
module bspc_switch_ctrl_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Inputs
	input wire logic cycle_start,
	input wire logic input_supply_ok,
	input wire logic enable_ok,
	input wire logic boot_uv,
	input wire logic feedback_over,
	input wire logic peak_current_trip,
	input wire logic ls_source_over,
	input wire logic ls_sink_over,
	// Outputs
	input wire logic hs_on,
	input wire logic ls_on,
	input wire logic active,
	input wire logic hiccup_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_both_low2;
		!hs_on && !ls_on ##1 !hs_on && !ls_on;
	endsequence
	sequence s_hs_held_off;
		!hs_on [*4];
	endsequence
	a_no_overlap: assert property (!(hs_on && ls_on)) else $error("overlap");
	a_dead_after_hs: assert property ($fell(hs_on) |-> s_both_low2) else $error("dead time");
	a_boot_uv_off: assert property (boot_uv |=> !hs_on) else $error("boot uv");
	a_ovp_off: assert property (feedback_over |=> !hs_on) else $error("ovp");
	a_peak_off: assert property (peak_current_trip |=> !hs_on) else $error("peak");
	a_sink_off: assert property (ls_sink_over && !boot_uv |=> !ls_on) else $error("sink");
	a_source_skip: assert property (cycle_start && ls_source_over && !hs_on |=> s_hs_held_off) else $error("source");
	a_turn_on_cycle: assert property ($rose(hs_on) |-> $past(cycle_start, 3) || $past(cycle_start, 4) ||
		$past(cycle_start, 5)) else $error("turn on");
	a_hiccup_off: assert property (hiccup_out |-> !hs_on && !ls_on) else $error("hiccup");
	a_active_follow: assert property ($past(rstn) |-> active == $past(input_supply_ok && enable_ok)) else $error("active");
	a_enable_stop: assert property (!enable_ok |-> ##[1:3] (!hs_on && !ls_on)) else $error("enable");
endmodule
bind bspc_switch_ctrl bspc_switch_ctrl_asserts bspc_switch_ctrl_asserts_inst (.clock(clock), .rstn(rstn),
	.cycle_start(cycle_start), .input_supply_ok(input_supply_ok), .enable_ok(enable_ok), .boot_uv(boot_uv),
	.feedback_over(feedback_over), .peak_current_trip(peak_current_trip), .ls_source_over(ls_source_over),
	.ls_sink_over(ls_sink_over), .hs_on(hs_on), .ls_on(ls_on), .active(active), .hiccup_out(hiccup_out));
`default_nettype wire

// ==== tb/bspc_switch_ctrl_tb.sv ====
`default_nettype none
module bspc_switch_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rstn = 0, cycle_start, off_request = 0, input_supply_ok = 0, enable_ok = 0, boot_uv = 0;
	logic feedback_over = 0, feedback_release = 1, peak_current_trip = 0, comp_clamped = 0;
	logic ls_source_over = 0, ls_sink_over = 0, hs_on, ls_on, active, hiccup_out;
	int errors = 0, checks = 0;
	always #10 clock = ~clock;
	bspc_osc_model bspc_osc_model_inst (.clock(clock), .rstn(rstn), .cycle_start(cycle_start));
	// Short hiccup counts keep the run brief
	bspc_switch_ctrl #(.HICCUP_WAIT(4), .HICCUP_TIME(8)) bspc_switch_ctrl_inst (.clock(clock), .rstn(rstn),
		.cycle_start(cycle_start), .off_request(off_request), .input_supply_ok(input_supply_ok),
		.enable_ok(enable_ok), .boot_uv(boot_uv), .feedback_over(feedback_over),
		.feedback_release(feedback_release), .peak_current_trip(peak_current_trip), .comp_clamped(comp_clamped),
		.ls_source_over(ls_source_over), .ls_sink_over(ls_sink_over), .hs_on(hs_on), .ls_on(ls_on),
		.active(active), .hiccup_out(hiccup_out));
	task finish_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	function logic pick(input int s);
		return s == 0 ? hs_on : s == 1 ? ls_on : s == 2 ? hiccup_out : active;
	endfunction
	task wt(input int s, input logic v);
		for (int i = 0; i < 400 && pick(s) !== v; i++)
			cyc(1);
		if (pick(s) !== v)
		begin
			errors++;
			$display("CHECK FAILED %0t timeout", $time);
			finish_test;
		end
	endtask
	task trip;
		@(posedge clock) peak_current_trip <= 1;
		@(posedge clock) peak_current_trip <= 0;
		#1;
	endtask
	task t_start;
		@(posedge clock) enable_ok <= 1;
		cyc(30);
		chk(active === 0 && hs_on === 0, "supply low");
		@(posedge clock) input_supply_ok <= 1;
		wt(3, 1);
		wt(0, 1);
		chk(ls_on === 0, "start");
		$display("end start");
	endtask
	task t_duty;
		trip;
		chk(hs_on === 0, "peak");
		wt(1, 1);
		chk(hs_on === 0, "swap");
		wt(0, 1);
		@(posedge clock) off_request <= 1;
		repeat (5) @(posedge clock);
		off_request <= 0;
		cyc(1);
		chk(hs_on === 1, "short off");
		cyc(25);
		chk(hs_on === 1, "full duty");
		@(posedge clock) boot_uv <= 1;
		cyc(1);
		chk(hs_on === 0, "boot uv");
		wt(1, 1);
		chk(hs_on === 0, "recharge");
		@(posedge clock) boot_uv <= 0;
		$display("end duty");
	endtask
	task t_ovp;
		wt(0, 1);
		@(posedge clock) feedback_over <= 1;
		feedback_release <= 0;
		cyc(1);
		chk(hs_on === 0, "ovp");
		wt(1, 1);
		@(posedge clock) feedback_over <= 0;
		cyc(30);
		chk(hs_on === 0, "ovp held");
		@(posedge clock) feedback_release <= 1;
		wt(0, 1);
		$display("end ovp");
	endtask
	task t_source;
		trip;
		wt(1, 1);
		@(posedge clock) ls_source_over <= 1;
		cyc(45);
		chk(hs_on === 0 && ls_on === 1, "source");
		@(posedge clock) ls_source_over <= 0;
		wt(0, 1);
		chk(ls_on === 0, "source resume");
		$display("end source");
	endtask
	task t_sink;
		trip;
		wt(1, 1);
		@(posedge clock) ls_sink_over <= 1;
		@(posedge clock) ls_sink_over <= 0;
		cyc(3);
		chk(ls_on === 0 && hs_on === 0, "sink");
		// Sourcing limit blocks the high side, so only the lockout keeps the low side off
		@(posedge clock) ls_source_over <= 1;
		cyc(25);
		chk(ls_on === 0 && hs_on === 0, "sink lock");
		// Boot undervoltage is the only way past the sink lockout without a high-side pulse
		@(posedge clock) boot_uv <= 1;
		wt(1, 1);
		chk(hs_on === 0, "sink unlock");
		@(posedge clock) boot_uv <= 0;
		ls_source_over <= 0;
		$display("end sink");
	endtask
	task t_hiccup;
		@(posedge clock) comp_clamped <= 1;
		cyc(60);
		chk(hiccup_out === 0, "hiccup early");
		wt(2, 1);
		@(posedge clock) comp_clamped <= 0;
		cyc(120);
		chk(hiccup_out === 1 && hs_on === 0, "hiccup");
		wt(2, 0);
		wt(0, 1);
		$display("end hiccup");
	endtask
	task t_enable;
		@(posedge clock) enable_ok <= 0;
		cyc(3);
		chk(active === 0, "disable");
		cyc(40);
		chk(hs_on === 0 && ls_on === 0, "shutdown");
		$display("end enable");
	endtask
	initial
	begin
		repeat (3) @(posedge clock);
		rstn <= 1;
		t_start;
		t_duty;
		t_ovp;
		t_source;
		t_sink;
		t_hiccup;
		t_enable;
		finish_test;
	end
endmodule
`default_nettype wire
